/* File: pkg/pid_pkg.sv */
// Package: command codes, identification constants, fault field layout and carriers
package pid_pkg;

    // ------------------------------------------------------------------
    // Command codes
    // ------------------------------------------------------------------
    localparam logic [7:0] PID_CMD_SIM_FAULT = 8'hF1;
    localparam logic [7:0] PID_CMD_ID_WORD   = 8'hFC;
    localparam logic [7:0] PID_CMD_ID_BLOCK  = 8'hFD;

    // ------------------------------------------------------------------
    // Identification sizes
    // ------------------------------------------------------------------
    localparam int unsigned PID_WORD_BYTES  = 2;
    localparam int unsigned PID_BLOCK_BYTES = 6;
    localparam logic [7:0]  PID_BLOCK_COUNT = 8'h06;

    // ------------------------------------------------------------------
    // Fault simulation field positions
    // ------------------------------------------------------------------
    localparam int unsigned PID_BIT_FAULT_PERSIST = 15;
    localparam int unsigned PID_BIT_SIM_OT        = 14;
    localparam int unsigned PID_BIT_SIM_IOUT_OC   = 12;
    localparam int unsigned PID_BIT_SIM_UVLO      = 11;
    localparam int unsigned PID_BIT_SIM_VIN_OV    = 10;
    localparam int unsigned PID_BIT_SIM_VOUT_UV   = 9;
    localparam int unsigned PID_BIT_SIM_VOUT_OV   = 8;
    localparam int unsigned PID_BIT_WARN_PERSIST  = 7;
    localparam logic [15:0] PID_SIM_RESET         = 16'h0000;
    // Bits that may force a comparator while conversion is off
    localparam logic [15:0] PID_OFF_ALLOWED_MASK  = 16'h0900;
    // Fault and warning request bits (persistence and reserved bits excluded)
    localparam logic [15:0] PID_FAULT_MASK        = 16'h5F00;
    localparam logic [15:0] PID_WARN_MASK         = 16'h001B;

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic       valid;
        logic       is_write;
        logic       is_block;
        logic [7:0] code;
    } pid_cmd_s;

    typedef struct packed {
        logic       valid;
        logic       last;
        logic [7:0] data;
    } pid_byte_s;

endpackage : pid_pkg

/* File: hdl/pid_id_rom.sv */
// Identification byte store with registered read data
`timescale 1ns/1ns
module pid_id_rom
    import pid_pkg::*;
#(
    parameter logic [15:0] ID_WORD  = 16'h1234, // Arbitrary neutral identity
    parameter logic [47:0] ID_BLOCK = 48'hA1B2C3D4E5F6 // Arbitrary neutral identity
) (
    input  wire logic       clk_i,
    input  wire logic       resetn_i,
    input  wire logic       sel_block_i,
    input  wire logic [2:0] index_i,
    output logic [7:0]      data_o
);

    // ------------------------------------------------------------------
    // Byte select
    // ------------------------------------------------------------------
    // Word low byte first; block count then bits 47:40 first
    logic [7:0] word_byte;
    logic [7:0] block_byte;
    assign word_byte  = (index_i == 3'h0) ? ID_WORD[7:0] : ID_WORD[15:8];
    assign block_byte = (index_i == 3'h0) ? PID_BLOCK_COUNT
                      : ID_BLOCK[8*(PID_BLOCK_BYTES-index_i) +: 8];

    // Registered read; constants cannot be altered by any write
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            data_o <= 8'h00;
        end else begin
            data_o <= sel_block_i ? block_byte : word_byte;
        end
    end

endmodule : pid_id_rom

/* File: hdl/pid_fault_gate.sv */
// Gating of simulated faults by conversion enable
`timescale 1ns/1ns
module pid_fault_gate
    import pid_pkg::*;
(
    input  wire logic [15:0] sim_i,
    input  wire logic        conv_en_i,
    output logic [15:0]      force_o
);

    // ------------------------------------------------------------------
    // Gate
    // ------------------------------------------------------------------
    // Only uvlo and output overvoltage pass while conversion is off
    logic [15:0] req;
    assign req     = sim_i & (PID_FAULT_MASK | PID_WARN_MASK);
    assign force_o = conv_en_i ? req
                               : (req & PID_OFF_ALLOWED_MASK);

endmodule : pid_fault_gate

/* File: hdl/pid_top.sv */
// Platform identification commands and simulated fault control
// Notes on behaviour
// - Uvlo and output overvoltage may force when off
// - Other simulated faults only act when enabled
// - Persistence keeps re-applying gated faults
// - Read Word FCh returns fixed 16-bit identity
// - Block Read FDh returns the count byte, then fixed six bytes
// - Write Word FCh acknowledged, nothing stored
// - Block Write FDh acknowledged, nothing stored
// - Readback after writes unchanged
// - Identity writes set no comm status bits
// - Persist 0 clears after response; 1 holds
`timescale 1ns/1ns
module pid_top
    import pid_pkg::*;
#(
    parameter logic [15:0] ID_WORD  = 16'h1234,       // Arbitrary neutral identity
    parameter logic [47:0] ID_BLOCK = 48'hA1B2C3D4E5F6 // Arbitrary neutral identity
) (
    input  wire logic        clk_i,
    input  wire logic        resetn_i,
    input  wire pid_cmd_s    cmd_i,          // Command start, one cycle
    input  wire logic [15:0] wr_word_i,      // Write Word data with cmd_i
    input  wire logic        wr_byte_i,      // Block write data byte strobe
    input  wire logic        rd_next_i,      // Host takes current read byte
    input  wire logic        conv_en_i,      // Power conversion enabled
    input  wire logic        fault_resp_i,   // One fault response completed
    output pid_byte_s        rd_o,           // Read byte stream
    output logic             ack_o,          // Command accepted
    output logic             nack_o,         // Unsupported command
    output logic             cml_err_o,      // Communication status event
    output logic [15:0]      sim_reg_o,      // Stored fault simulation word
    output logic [15:0]      force_o         // Comparator force lines
);

    // ------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------
    // Identity code test
    function automatic logic is_id(input logic [7:0] code);
        is_id = (code == PID_CMD_ID_WORD) || (code == PID_CMD_ID_BLOCK);
    endfunction : is_id

    // Only the identity block travels framed as a block; a word command
    // framed as a block, or the reverse, is a protocol error, not a hit
    function automatic logic fmt_ok(input pid_cmd_s c);
        fmt_ok = (c.is_block == (c.code == PID_CMD_ID_BLOCK));
    endfunction : fmt_ok

    // Byte of a 16-bit word in transfer order, low byte first
    function automatic logic [7:0] word_lane(input logic [15:0] w, input logic [2:0] i);
        word_lane = (i == 3'h0) ? w[7:0] : w[15:8];
    endfunction : word_lane

    logic hit_id;
    logic hit_sim;
    logic fmt_good;
    logic known;
    logic blk_cmd;
    logic sim_cmd;
    // Named decode terms keep the sequencer and the answers in step
    assign fmt_good = fmt_ok(cmd_i);
    assign hit_id   = cmd_i.valid && is_id(cmd_i.code) && fmt_good;
    assign hit_sim  = cmd_i.valid && (cmd_i.code == PID_CMD_SIM_FAULT) && fmt_good;
    assign known    = hit_id || hit_sim;
    assign blk_cmd  = cmd_i.code == PID_CMD_ID_BLOCK;
    assign sim_cmd  = cmd_i.code == PID_CMD_SIM_FAULT;

    // ------------------------------------------------------------------
    // Read sequencer
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        PID_IDLE = 2'b00,
        PID_LOAD = 2'b01,
        PID_SEND = 2'b11
    } pid_state_e;

    pid_state_e state_reg;
    pid_state_e state_next;
    logic       blk_reg;
    logic       blk_next;
    logic [2:0] idx_reg;
    logic [2:0] idx_next;
    logic [2:0] last_idx;
    logic [7:0] rom_data;
    logic       start_rd;
    logic       src_reg;
    logic       src_next;
    logic       rd_step;
    logic       rd_final;
    logic [7:0] sim_byte_reg;
    logic [7:0] rd_byte;
    // Word: 2 bytes; block: count byte plus 6 bytes
    assign last_idx = blk_reg ? 3'(PID_BLOCK_BYTES) : 3'(PID_WORD_BYTES - 1);
    // The fault simulation word reads back like any other Read Word,
    // so a host never waits on an acknowledged read that sends nothing
    assign start_rd = (hit_id || hit_sim) && !cmd_i.is_write;
    // Host took the byte on show; the last one ends the stream
    assign rd_step  = (state_reg == PID_SEND) && rd_next_i;
    assign rd_final = (idx_reg == last_idx);

    // The three-bit byte index must reach the last block byte
    if (PID_BLOCK_BYTES >= (1 << $bits(idx_reg))) begin : g_bad_block_len
        $error("identity block too long for the byte index");
    end

    // Next state; a new read command restarts the stream, except in PID_LOAD where it is dropped
    always_comb begin
        state_next = state_reg;
        blk_next   = blk_reg;
        src_next   = src_reg;
        idx_next   = idx_reg;
        case (state_reg)
            PID_IDLE: begin
                if (start_rd) begin
                    state_next = PID_LOAD;
                    blk_next   = blk_cmd;
                    src_next   = sim_cmd;
                    idx_next   = 3'h0;
                end
            end
            PID_LOAD: begin
                // One cycle for the registered byte sources to answer
                state_next = PID_SEND;
            end
            PID_SEND: begin
                if (start_rd) begin
                    state_next = PID_LOAD;
                    blk_next   = blk_cmd;
                    src_next   = sim_cmd;
                    idx_next   = 3'h0;
                end else if (rd_step && rd_final) begin
                    state_next = PID_IDLE;
                end else if (rd_step) begin
                    state_next = PID_LOAD;
                    idx_next   = idx_reg + 3'h1;
                end
            end
            default: begin
                state_next = PID_IDLE;
            end
        endcase
    end

    // Sequencer registers
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            state_reg <= PID_IDLE;
            blk_reg   <= 1'b0;
            src_reg   <= 1'b0;
            idx_reg   <= 3'h0;
        end else begin
            state_reg <= state_next;
            blk_reg   <= blk_next;
            src_reg   <= src_next;
            idx_reg   <= idx_next;
        end
    end

    // Constant identity store, byte addressed
    pid_id_rom #(
        .ID_WORD  (ID_WORD),
        .ID_BLOCK (ID_BLOCK)
    ) u_rom (
        .clk_i       (clk_i),
        .resetn_i    (resetn_i),
        .sel_block_i (blk_next),
        .index_i     (idx_next),
        .data_o      (rom_data)
    );

    // Read byte presented once the store has answered
    assign rd_o.valid = (state_reg == PID_SEND);
    assign rd_o.last  = (state_reg == PID_SEND) && (idx_reg == last_idx);
    // Source select: identity store or the fault simulation word
    assign rd_byte    = src_reg ? sim_byte_reg : rom_data;
    assign rd_o.data  = (state_reg == PID_SEND) ? rd_byte : 8'h00;

    // ------------------------------------------------------------------
    // Answers and status
    // ------------------------------------------------------------------
    // Identity writes and block data bytes are taken and dropped; the
    // block write strobe needs no state since nothing is ever kept
    logic ack_reg;
    logic nack_reg;
    logic ack_set;
    logic nack_set;
    // Identity writes end here: acknowledged, with no store behind them
    assign ack_set  = known || wr_byte_i;
    // Unknown codes and wrongly framed transfers are refused
    assign nack_set = cmd_i.valid && !known;

    // Answer pulses, one cycle each
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            ack_reg  <= 1'b0;
            nack_reg <= 1'b0;
        end else begin
            ack_reg  <= ack_set;
            nack_reg <= nack_set;
        end
    end
    assign ack_o  = ack_reg;
    assign nack_o = nack_reg;
    // Only refused commands raise status, wrongly framed ones included; identity writes never do
    assign cml_err_o = nack_reg;

    // ------------------------------------------------------------------
    // Fault simulation word
    // ------------------------------------------------------------------
    logic [15:0] sim_reg;
    logic [15:0] sim_next;
    logic [15:0] auto_clr;
    logic        sim_wr;
    assign sim_wr = hit_sim && cmd_i.is_write;
    // Non-persistent groups drop after one response, with conversion on or off
    assign auto_clr = (sim_reg[PID_BIT_FAULT_PERSIST] ? 16'h0000 : PID_FAULT_MASK)
                    | (sim_reg[PID_BIT_WARN_PERSIST]  ? 16'h0000 : PID_WARN_MASK);
    // A fresh write wins over the automatic removal
    assign sim_next = sim_wr ? wr_word_i
                    : (fault_resp_i ? (sim_reg & ~auto_clr) : sim_reg);

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            sim_reg <= PID_SIM_RESET;
        end else begin
            sim_reg <= sim_next;
        end
    end
    assign sim_reg_o = sim_reg;

    // Fault simulation read byte, registered on the same edges as the
    // identity store so both sources reach the read path equally late
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            sim_byte_reg <= 8'h00;
        end else begin
            sim_byte_reg <= word_lane(sim_reg, idx_next);
        end
    end

    // Persistent faults stay asserted, so the gate re-applies them after
    // each restart while conversion is enabled
    pid_fault_gate u_gate (
        .sim_i     (sim_reg),
        .conv_en_i (conv_en_i),
        .force_o   (force_o)
    );

endmodule : pid_top

/* File: test/pid_top_assertions.sv */
// Checker for identity commands and simulated fault gating
`timescale 1ns/1ns
module pid_top_assertions
    import pid_pkg::*;
#(
    parameter logic [15:0] ID_WORD  = 16'h1234,        // Arbitrary neutral identity
    parameter logic [47:0] ID_BLOCK = 48'hA1B2C3D4E5F6 // Arbitrary neutral identity
) (
    input wire logic        clk_i,
    input wire logic        resetn_i,
    input wire pid_cmd_s    cmd_i,
    input wire logic [15:0] wr_word_i,
    input wire logic        wr_byte_i,
    input wire logic        rd_next_i,
    input wire logic        conv_en_i,
    input wire logic        fault_resp_i,
    input wire pid_byte_s   rd_o,
    input wire logic        ack_o,
    input wire logic        nack_o,
    input wire logic        cml_err_o,
    input wire logic [15:0] sim_reg_o,
    input wire logic [15:0] force_o
);
    // ------------------------------------------------------------
    // Write decode and read sequences
    // ------------------------------------------------------------
    wire logic fmt_good = cmd_i.is_block == (cmd_i.code == PID_CMD_ID_BLOCK);
    wire logic sim_wr   = cmd_i.valid && cmd_i.is_write && fmt_good
                          && cmd_i.code == PID_CMD_SIM_FAULT;
    wire logic id_wr    = cmd_i.valid && cmd_i.is_write && fmt_good
                          && cmd_i.code inside {PID_CMD_ID_WORD, PID_CMD_ID_BLOCK};
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    sequence s_take(logic [7:0] c);
        cmd_i.valid && !cmd_i.is_write && fmt_good && cmd_i.code == c;
    endsequence
    sequence s_first(logic [7:0] d);
        rd_o.valid && rd_o.data == d;
    endsequence
    // Bits 14, 12 and 10 must stay dark while conversion is off
    AST_OFF_PASS: assert property (!conv_en_i |-> force_o == (sim_reg_o & 16'h0900))
        else $error("off force mismatch");
    AST_OFF_HELD: assert property (!conv_en_i |-> (force_o & 16'h5400) == 16'h0000)
        else $error("gated fault leaked");
    AST_ON_PASS: assert property (conv_en_i |-> force_o == (sim_reg_o & 16'h5F1B))
        else $error("on force mismatch");
    AST_SIM_LOAD: assert property (sim_wr |=> sim_reg_o == $past(wr_word_i))
        else $error("sim word not stored");
    AST_AUTO_CLEAR: assert property (fault_resp_i && !sim_reg_o[15] && !sim_wr
        |=> (sim_reg_o & 16'h5F00) == 16'h0000) else $error("faults not cleared");
    AST_PERSIST_HOLD: assert property (fault_resp_i && sim_reg_o[15] && !sim_wr
        |=> $stable(sim_reg_o[15:8])) else $error("persistent faults dropped");
    AST_ID_WR_ACK: assert property (id_wr |=> ack_o && !nack_o && !cml_err_o)
        else $error("identity write not acked cleanly");
    AST_ID_WR_KEEP: assert property (id_wr && !fault_resp_i |=> $stable(sim_reg_o))
        else $error("identity write changed state");
    AST_BYTE_ACK: assert property (wr_byte_i |=> ack_o && !cml_err_o)
        else $error("block byte not acked cleanly");
    AST_WORD_FIRST: assert property (s_take(PID_CMD_ID_WORD) |-> ##2 s_first(ID_WORD[7:0]))
        else $error("word low byte wrong");
    AST_BLOCK_COUNT: assert property (s_take(PID_CMD_ID_BLOCK) |-> ##2 s_first(PID_BLOCK_COUNT))
        else $error("block count wrong");
endmodule : pid_top_assertions

bind pid_top pid_top_assertions #(.ID_WORD(ID_WORD), .ID_BLOCK(ID_BLOCK)) u_chk (
    .clk_i(clk_i), .resetn_i(resetn_i), .cmd_i(cmd_i), .wr_word_i(wr_word_i),
    .wr_byte_i(wr_byte_i), .rd_next_i(rd_next_i), .conv_en_i(conv_en_i),
    .fault_resp_i(fault_resp_i), .rd_o(rd_o), .ack_o(ack_o), .nack_o(nack_o),
    .cml_err_o(cml_err_o), .sim_reg_o(sim_reg_o), .force_o(force_o));

/* File: test/pid_host_model.sv */
// Host model issuing command, write byte and read byte cycles
`timescale 1ns/1ns
module pid_host_model
    import pid_pkg::*;
(
    input  wire logic      clk_i,
    input  wire pid_byte_s rd_i,
    output pid_cmd_s       cmd_o,
    output logic [15:0]    wr_word_o,
    output logic           wr_byte_o,
    output logic           rd_next_o
);
    // Idle levels; unqualified data shows junk so nothing relies on it
    initial begin
        cmd_o = '0;
        wr_word_o = 16'hA5A5;
        wr_byte_o = 1'b0;
        rd_next_o = 1'b0;
    end
    // One-cycle command strobe; data inverted once it is no longer qualified
    task automatic send(input logic w, input logic b, input logic [7:0] c, input logic [15:0] d);
        @(posedge clk_i);
        cmd_o <= '{valid: 1'b1, is_write: w, is_block: b, code: c};
        wr_word_o <= d;
        @(posedge clk_i);
        cmd_o <= '0;
        wr_word_o <= ~d;
    endtask : send
    task automatic put_byte();
        @(posedge clk_i) wr_byte_o <= 1'b1;
        @(posedge clk_i) wr_byte_o <= 1'b0;
    endtask : put_byte
    // Bounded wait per byte; ok drops on timeout or a misplaced last flag
    task automatic fetch(input int n, output logic [63:0] v, output bit ok);
        int t;
        v = '0;
        ok = 1'b1;
        for (int i = 0; i < n; i++) begin
            t = 0;
            #1;
            while (rd_i.valid !== 1'b1 && t < 8) begin
                @(posedge clk_i) t++;
                #1;
            end
            if (t == 8 || rd_i.last !== (i == n - 1)) ok = 1'b0;
            v = {v[55:0], rd_i.data};
            @(posedge clk_i) rd_next_o <= 1'b1;
            @(posedge clk_i) rd_next_o <= 1'b0;
        end
    endtask : fetch
endmodule : pid_host_model

/* File: test/pmbus_platform_id_and_fault_sim_gating_test.sv */
// Testbench for identity commands and simulated fault gating
`timescale 1ns/1ns
module pmbus_platform_id_and_fault_sim_gating_test;
    import pid_pkg::*;
    localparam logic [15:0] ID_W = 16'h5A3C;         // Arbitrary identity value
    localparam logic [47:0] ID_B = 48'h0F1E2D3C5A69; // Arbitrary identity value
    logic        clk, resetn, conv_en, fault_resp, wr_byte, rd_next, ack, nack, cml;
    logic [15:0] wr_word, sim, frc;
    pid_cmd_s    cmd;
    pid_byte_s   rd;
    int          bad_count = 0;
    int          check_count = 0;
    pid_top #(.ID_WORD(ID_W), .ID_BLOCK(ID_B)) uut (.clk_i(clk), .resetn_i(resetn),
        .cmd_i(cmd), .wr_word_i(wr_word), .wr_byte_i(wr_byte), .rd_next_i(rd_next),
        .conv_en_i(conv_en), .fault_resp_i(fault_resp), .rd_o(rd), .ack_o(ack),
        .nack_o(nack), .cml_err_o(cml), .sim_reg_o(sim), .force_o(frc));
    pid_host_model host (.clk_i(clk), .rd_i(rd), .cmd_o(cmd), .wr_word_o(wr_word),
        .wr_byte_o(wr_byte), .rd_next_o(rd_next));
    // ------------------------------------------------------------
    // Clock, checks and scenarios
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    task automatic give_verdict();
        if (bad_count == 0 && check_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : give_verdict
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // A read that never completes is a mismatch; the run carries on
    task automatic read_id(input logic [7:0] c, input int n, input logic [63:0] exp);
        logic [63:0] v;
        bit ok;
        host.send(1'b0, c == PID_CMD_ID_BLOCK, c, 16'h0000);
        host.fetch(n, v, ok);
        if (!ok) chk(64'h0, 64'h1);
        chk(v, exp);
    endtask : read_id
    task automatic t_id_reads();
        read_id(PID_CMD_ID_WORD, 2, {ID_W[7:0], ID_W[15:8]});
        read_id(PID_CMD_ID_BLOCK, 7, {PID_BLOCK_COUNT, ID_B});
    endtask : t_id_reads
    task automatic t_id_writes();
        host.send(1'b1, 1'b0, PID_CMD_ID_WORD, 16'hFFFF);
        #1 chk({ack, nack, cml}, 3'b100);
        host.send(1'b1, 1'b1, PID_CMD_ID_BLOCK, 16'h0000);
        #1 chk({ack, nack, cml}, 3'b100);
        repeat (7) begin
            host.put_byte();
            #1 chk({ack, nack, cml}, 3'b100);
        end
        t_id_reads();
    endtask : t_id_writes
    task automatic pulse_resp();
        @(posedge clk) fault_resp <= 1'b1;
        @(posedge clk) fault_resp <= 1'b0;
        #1;
    endtask : pulse_resp
    // Off-state pass set, enabled pass set, auto clear, then persistence
    task automatic t_gate();
        host.send(1'b1, 1'b0, PID_CMD_SIM_FAULT, 16'h5F1B);
        #1 chk(frc, 16'h0900);
        @(posedge clk) conv_en <= 1'b1;
        #1 chk(frc, 16'h5F1B);
        pulse_resp();
        chk(frc, 16'h0000);
        host.send(1'b1, 1'b0, PID_CMD_SIM_FAULT, 16'hDF9B);
        pulse_resp();
        chk(frc, 16'h5F1B);
        read_id(PID_CMD_SIM_FAULT, 2, {8'h9B, 8'hDF});
        @(posedge clk) conv_en <= 1'b0;
        #1 chk(frc, 16'h0900);
    endtask : t_gate
    // Unknown code, then a word read framed as a block: both refused
    task automatic t_refused();
        host.send(1'b0, 1'b0, 8'hF0, 16'h0000);
        #1 chk({ack, nack, cml}, 3'b011);
        host.send(1'b0, 1'b1, PID_CMD_ID_WORD, 16'h0000);
        #1 chk({ack, nack, cml}, 3'b011);
        repeat (2) @(posedge clk);
        #1 chk(rd, 64'h0);
    endtask : t_refused
    // Every output idle just after a reset release
    task automatic t_reset_idle();
        #1 chk({sim, frc, rd, ack, nack, cml}, 64'h0);
    endtask : t_reset_idle
    // Mid-run reset with a stored fault word
    task automatic t_reset();
        @(posedge clk) resetn <= 1'b0;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        t_reset_idle();
    endtask : t_reset
    initial begin
        resetn = 1'b0;
        conv_en = 1'b0;
        fault_resp = 1'b0;
        repeat (16) @(posedge clk);
        resetn <= 1'b1;
        t_reset_idle();
        t_id_reads();
        t_id_writes();
        t_refused();
        t_gate();
        t_reset();
        t_id_reads();
        give_verdict();
    end
endmodule : pmbus_platform_id_and_fault_sim_gating_test
